// *** lsri_host_model.sv ***
`timescale 1ns/1ns
module lsri_host_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  localparam int HALF = 80;
  // idle bus: both lines released high
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  // start, msb-first byte, ack clock, stop
  task automatic xfer(input logic [7:0] head, input int stall, input int nrd,
                      output logic ack, output logic [15:0] rx);
    rx = 16'h0000;
    #HALF sda_drv = 1'h0;
    #HALF scl = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      #20 sda_drv = head[i];
      #(HALF - 20) scl = 1'h1;
      #HALF scl = 1'h0;
    end
    #20 sda_drv = 1'h1;
    // stall stretches clock low to provoke the bus timeout
    #(HALF - 20 + stall) scl = 1'h1;
    #40 ack = sda_line;
    #40 scl = 1'h0;
    if (head[0] && ack === 1'h0) begin
      for (int i = 8 * nrd - 1; i >= 0; i--) begin
        #HALF scl = 1'h1;
        #40 rx[i] = sda_line;
        #40 scl = 1'h0;
        // ack every byte but the last; a released line is the nack
        if (i % 8 == 0) begin
          #20 sda_drv = (i == 0);
          #(HALF - 20) scl = 1'h1;
          #HALF scl = 1'h0;
          #20 sda_drv = 1'h1;
        end
      end
    end
    #20 sda_drv = 1'h0;
    #(HALF - 20) scl = 1'h1;
    #HALF sda_drv = 1'h1;
    #HALF;
  endtask
endmodule

// *** lsri_pkg.sv ***
package lsri_pkg;

  // register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFF_RESULT = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_LOW = 8'h08;
  localparam logic [7:0] OFF_HIGH = 8'h0C;

  // configuration register field positions
  localparam int CFG_RN_LSB = 12;
  localparam int CFG_CT_BIT = 11;
  localparam int CFG_MODE_LSB = 9;
  localparam int CFG_OVF_BIT = 8;
  localparam int CFG_RDY_BIT = 7;
  localparam int CFG_FH_BIT = 6;
  localparam int CFG_FL_BIT = 5;
  localparam int CFG_LATCH_BIT = 4;
  localparam int CFG_POL_BIT = 3;
  localparam int CFG_FC_LSB = 0;
  localparam int LIM_EOC_LSB = 14;

  // reset values
  localparam logic [3:0] RN_RST = 4'hC;
  localparam logic CT_RST = 1'h1;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic LATCH_RST = 1'h1;
  localparam logic POL_RST = 1'h0;
  localparam logic [1:0] FC_RST = 2'h0;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [15:0] HIGH_RST = 16'hBFFF;

  // modes and codes
  localparam logic [3:0] RN_AUTO = 4'hC;
  localparam logic [3:0] RANGE_MAX = 4'hB;
  localparam logic [1:0] EOC_MARK = 2'h3;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [3:0] FLT_SAT = 4'h8;

  // auto-range decision thresholds, fraction of full scale in 12 bits
  localparam logic [11:0] AR_LOW2_THR = 12'h200;
  localparam logic [11:0] AR_LOW1_THR = 12'h600;
  localparam logic [11:0] AR_HIGH_THR = 12'hE00;

  // bus addresses
  localparam logic [4:0] ADDR_BASE = 5'h11;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [1:0] PIN_GND = 2'h0;
  localparam logic [1:0] PIN_VDD = 2'h1;
  localparam logic [1:0] PIN_SDA = 2'h2;
  localparam logic [1:0] PIN_SCL = 2'h3;

  // timing
  localparam int CLK_KHZ = 250000;
  localparam int TIMEOUT_MS = 28;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  localparam int ASSESS_MS = 10;
  localparam int STD_KHZ = 100;
  localparam int FAST_KHZ = 400;
  localparam int HS_KHZ = 2600;

  typedef struct packed {
    logic start;
    logic assess;
    logic [3:0] range;
    logic long_time;
  } lsri_conv_req_s;

  typedef struct packed {
    logic valid;
    logic ovf;
    logic [11:0] code;
  } lsri_conv_res_s;

endpackage

// *** lsri_top.sv ***
`timescale 1ns/1ns

module lsri_top #(
  parameter int TIMEOUT_CYC = lsri_pkg::TIMEOUT_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input wire logic ADDR_I,
  input wire logic INT_I,
  output logic INT_O,
  output logic INT_OE_N,
  output lsri_pkg::lsri_conv_req_s CONV_REQ,
  input wire lsri_pkg::lsri_conv_res_s CONV_RES
);

  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_WR, I2C_RD, I2C_HOLD} lsri_i2c_e;
  typedef enum logic {CV_IDLE, CV_WAIT} lsri_cv_e;

  // configuration state
  logic [3:0] rn;
  logic ct;
  logic [1:0] mode;
  logic latch;
  logic alert_polarity_field;
  logic [1:0] fc;
  logic ovf_flag;
  logic ready;
  logic fh;
  logic fl;
  logic int_act;
  logic [15:0] low_lim;
  logic [15:0] high_lim;
  logic [15:0] result;

  // bus slave state
  logic dp_wr;
  logic [7:0] dp_addr;

  // measurement state
  lsri_cv_e cv_st;
  logic [3:0] cur_range;
  logic assess_pend;
  logic [3:0] flt_cnt;
  logic [1:0] prev_out;

  // serial target state
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic [1:0] adr_sy;
  logic scl_d;
  logic sda_d;
  lsri_i2c_e i2c_st;
  logic [3:0] bit_cnt;
  logic [7:0] rx;
  logic [7:0] tx;
  logic rw;
  logic ara;
  logic host_ack;
  logic byte_sel;
  logic [2:0] addr_smp;
  logic [22:0] to_cnt;
  logic ara_done;

  // AHB-Lite decode; only whole-word singles are expected, HSIZE is not checked
  wire ahb_go = HSEL & HTRANS[1] & HREADY;
  wire a_in_map = HADDR[31:8] == 24'h000000;
  wire [7:0] a_off = HADDR[7:0];
  wire cfg_rd = ahb_go & ~HWRITE & a_in_map & (a_off == lsri_pkg::OFF_CONFIG);
  wire cfg_wr = dp_wr & (dp_addr == lsri_pkg::OFF_CONFIG);
  wire low_wr = dp_wr & (dp_addr == lsri_pkg::OFF_LOW);
  wire high_wr = dp_wr & (dp_addr == lsri_pkg::OFF_HIGH);
  wire [1:0] wr_mode = HWDATA[lsri_pkg::CFG_MODE_LSB +: 2];
  wire cfg_wr_run = cfg_wr & (wr_mode != lsri_pkg::MODE_OFF);
  wire [15:0] cfg_word = {rn, ct, mode, ovf_flag, ready, fh, fl, latch, alert_polarity_field, 1'b0, fc};
  wire [31:0] rd_mux = ~a_in_map ? 32'h00000000 :
                       (a_off == lsri_pkg::OFF_RESULT) ? {16'h0000, result} :
                       (a_off == lsri_pkg::OFF_CONFIG) ? {16'h0000, cfg_word} :
                       (a_off == lsri_pkg::OFF_LOW) ? {16'h0000, low_lim} :
                       (a_off == lsri_pkg::OFF_HIGH) ? {16'h0000, high_lim} : 32'h00000000;

  // automatic ranging selected by field code
  wire auto_rng = rn == lsri_pkg::RN_AUTO;
  wire eoc = low_lim[lsri_pkg::LIM_EOC_LSB +: 2] == lsri_pkg::EOC_MARK;

  wire meas_done = (cv_st == CV_WAIT) & CONV_RES.valid;
  wire report = meas_done & ~(auto_rng & (assess_pend | CONV_RES.ovf));
  wire [3:0] rng_used = CONV_REQ.range;

  // compare in linear units; exponent is the range that produced the code
  wire [26:0] res_lin = {15'h0000, CONV_RES.code} << rng_used;
  wire [26:0] hi_lin = {15'h0000, high_lim[11:0]} << high_lim[15:12];
  wire [26:0] lo_lin = {15'h0000, low_lim[11:0]} << low_lim[15:12];
  wire is_high = res_lin > hi_lin;
  wire is_low = res_lin < lo_lin;
  wire [1:0] outcome = {is_high, is_low};

  // run length restarts on changed outcome
  wire [3:0] flt_inc = (flt_cnt == lsri_pkg::FLT_SAT) ? flt_cnt : flt_cnt + 4'h1;
  wire [3:0] next_cnt = (outcome == prev_out) ? flt_inc : 4'h1;
  wire [3:0] flt_need = 4'h1 << fc;
  // act only after the configured run
  wire run_met = next_cnt >= flt_need;
  wire hit_high = report & is_high & run_met;
  wire hit_low = report & is_low & ~is_high & run_met;

  wire [3:0] next_range =
    ((CONV_RES.code < lsri_pkg::AR_LOW2_THR) & (rng_used >= 4'h2)) ? rng_used - 4'h2 :
    ((CONV_RES.code < lsri_pkg::AR_LOW1_THR) & (rng_used >= 4'h1)) ? rng_used - 4'h1 :
    ((CONV_RES.code > lsri_pkg::AR_HIGH_THR) & (rng_used < lsri_pkg::RANGE_MAX)) ?
      rng_used + 4'h1 : rng_used;

  // pick first range from assessment, taken at the top range
  logic [3:0] pick;
  always_comb begin
    pick = lsri_pkg::RANGE_MAX;
    for (int i = 11; i >= 0; i--) begin
      if (({11'h000, CONV_RES.code} << (11 - i)) < {11'h000, lsri_pkg::AR_HIGH_THR}) begin
        pick = 4'(i);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      dp_wr <= ahb_go & HWRITE & a_in_map;
      dp_addr <= a_off;
      HRDATA <= (ahb_go & ~HWRITE) ? rd_mux : 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // conversion sequencer towards the optical front end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cv_st <= CV_IDLE;
      CONV_REQ <= '0;
      cur_range <= lsri_pkg::RANGE_MAX;
      assess_pend <= 1'b1;
    end else begin
      CONV_REQ.start <= 1'b0;
      // leaving auto mode re-arms the initial assessment
      if (!auto_rng) begin
        assess_pend <= 1'b1;
      end
      unique case (cv_st)
        CV_IDLE: begin
          if (mode != lsri_pkg::MODE_OFF) begin
            CONV_REQ.start <= 1'b1;
            // short assessment at the top range
            CONV_REQ.assess <= auto_rng & assess_pend;
            CONV_REQ.range <= !auto_rng ? rn :
                              assess_pend ? lsri_pkg::RANGE_MAX : cur_range;
            CONV_REQ.long_time <= ct;
            cv_st <= CV_WAIT;
          end
        end
        CV_WAIT: begin
          if (CONV_RES.valid) begin
            cv_st <= CV_IDLE;
            if (auto_rng && assess_pend) begin
              cur_range <= pick;
              assess_pend <= 1'b0;
            end else if (auto_rng && CONV_RES.ovf) begin
              assess_pend <= 1'b1;
            end else if (auto_rng) begin
              cur_range <= next_range;
            end
          end
        end
      endcase
    end
  end

  // configuration, limits, result, flags and interrupt state
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rn <= lsri_pkg::RN_RST;
      ct <= lsri_pkg::CT_RST;
      mode <= lsri_pkg::MODE_RST;
      latch <= lsri_pkg::LATCH_RST;
      alert_polarity_field <= lsri_pkg::POL_RST;
      fc <= lsri_pkg::FC_RST;
      low_lim <= lsri_pkg::LOW_RST;
      high_lim <= lsri_pkg::HIGH_RST;
      result <= 16'h0000;
      ovf_flag <= 1'b0;
      ready <= 1'b0;
      fh <= 1'b0;
      fl <= 1'b0;
      int_act <= 1'b0;
      flt_cnt <= 4'h0;
      prev_out <= 2'h0;
    end else begin
      if (report && mode == lsri_pkg::MODE_SINGLE) begin
        mode <= lsri_pkg::MODE_OFF;
      end
      if (cfg_wr) begin
        rn <= HWDATA[lsri_pkg::CFG_RN_LSB +: 4];
        ct <= HWDATA[lsri_pkg::CFG_CT_BIT];
        mode <= wr_mode;
        latch <= HWDATA[lsri_pkg::CFG_LATCH_BIT];
        alert_polarity_field <= HWDATA[lsri_pkg::CFG_POL_BIT];
        fc <= HWDATA[lsri_pkg::CFG_FC_LSB +: 2];
      end
      if (low_wr) begin
        low_lim <= HWDATA[15:0];
      end
      if (high_wr) begin
        high_lim <= HWDATA[15:0];
      end
      // clears first, so a same-cycle event below wins
      // any config read clears ready
      if (cfg_rd || cfg_wr_run) begin
        ready <= 1'b0;
      end
      // latched read releases pin and flags
      if (cfg_rd && latch) begin
        fh <= 1'b0;
        fl <= 1'b0;
      end
      // transparent mode leaves pin alone unless end-of-conversion
      if ((cfg_rd && (latch || eoc)) || (cfg_wr_run && eoc)) begin
        int_act <= 1'b0;
      end
      if (ara_done) begin
        int_act <= 1'b0;
      end
      if (report) begin
        result <= {rng_used, CONV_RES.code};
        ovf_flag <= CONV_RES.ovf;
        ready <= 1'b1;
        flt_cnt <= next_cnt;
        prev_out <= outcome;
        if (latch) begin
          // latched window holds cause and pin
          if (hit_high) begin
            fh <= 1'b1;
            int_act <= 1'b1;
          end
          if (hit_low) begin
            fl <= 1'b1;
            int_act <= 1'b1;
          end
        end else begin
          if (hit_high) begin
            fh <= 1'b1;
            fl <= 1'b0;
            int_act <= 1'b1;
          end
          if (hit_low) begin
            fl <= 1'b1;
            fh <= 1'b0;
            int_act <= 1'b0;
          end
        end
        if (eoc) begin
          int_act <= 1'b1;
        end
      end
    end
  end

  // open-drain interrupt pin, only ever pulls low
  always_ff @(posedge CLK) begin
    if (SRST) begin
      INT_O <= 1'b0;
      INT_OE_N <= 1'b1;
    end else begin
      INT_O <= 1'b0;
      // polarity 0 drives low when active
      INT_OE_N <= ~(int_act ^ alert_polarity_field);
    end
  end

  // 4 ns sampling resolves even 2.6 MHz clocks
  always_ff @(posedge CLK) begin
    if (SRST) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      adr_sy <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], SCL_I};
      sda_sy <= {sda_sy[0], SDA_I};
      adr_sy <= {adr_sy[0], ADDR_I};
      scl_d <= scl_sy[1];
      sda_d <= sda_sy[1];
    end
  end

  wire scl = scl_sy[1];
  wire sda = sda_sy[1];
  wire adr = adr_sy[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  // data edge with clock high is start or stop
  wire start_cond = scl & scl_d & sda_d & ~sda;
  wire stop_cond = scl & scl_d & ~sda_d & sda;
  wire in_xfer = (i2c_st == I2C_ADDR) | (i2c_st == I2C_WR) | (i2c_st == I2C_RD);

  // address pin tie seen at start, first fall, first rise
  // tie to a bus line is told apart by how the pin follows SDA and SCL
  wire [1:0] pin_code = (addr_smp == 3'h7) ? lsri_pkg::PIN_VDD :
                        (addr_smp == 3'h1) ? lsri_pkg::PIN_SDA :
                        (addr_smp == 3'h5) ? lsri_pkg::PIN_SCL : lsri_pkg::PIN_GND;
  wire [6:0] own_addr = {lsri_pkg::ADDR_BASE, pin_code};
  wire addr_hit = rx[7:1] == own_addr;
  // alert response only answered in latched mode
  wire ara_hit = (rx[7:1] == lsri_pkg::ARA_ADDR) & rx[0] & latch & int_act;
  wire [7:0] tx_byte = ara ? {own_addr, 1'b0} : (byte_sel ? result[7:0] : result[15:8]);
  wire to_hit = to_cnt == 23'(TIMEOUT_CYC - 1);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      i2c_st <= I2C_IDLE;
      bit_cnt <= 4'h0;
      rx <= 8'h00;
      tx <= 8'hFF;
      rw <= 1'b0;
      ara <= 1'b0;
      host_ack <= 1'b0;
      byte_sel <= 1'b0;
      addr_smp <= 3'h0;
      to_cnt <= 23'h000000;
      ara_done <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else begin
      ara_done <= 1'b0;
      SDA_O <= 1'b0;
      to_cnt <= (~scl && i2c_st != I2C_IDLE) ? to_cnt + 23'h000001 : 23'h000000;
      if (to_hit) begin
        // stuck clock resets the bus machine
        i2c_st <= I2C_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (start_cond) begin
        // fresh address pin sample each transaction
        i2c_st <= I2C_ADDR;
        bit_cnt <= 4'h0;
        ara <= 1'b0;
        byte_sel <= 1'b0;
        addr_smp[2] <= adr;
        SDA_OE_N <= 1'b1;
      end else if (stop_cond) begin
        i2c_st <= I2C_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (scl_rise && in_xfer) begin
        // shift in on rising clock edges
        bit_cnt <= bit_cnt + 4'h1;
        if (i2c_st == I2C_ADDR && bit_cnt == 4'h0) begin
          addr_smp[0] <= adr;
        end
        // eight bits MSB first, then acknowledge
        if (bit_cnt < 4'h8) begin
          rx <= {rx[6:0], sda};
        end else if (i2c_st == I2C_RD) begin
          host_ack <= ~sda;
        end
      end else if (scl_fall && in_xfer) begin
        if (i2c_st == I2C_ADDR && bit_cnt == 4'h0) begin
          addr_smp[1] <= adr;
        end
        if (bit_cnt == 4'h8) begin
          unique case (i2c_st)
            I2C_ADDR: begin
              if (addr_hit || ara_hit) begin
                SDA_OE_N <= 1'b0;
                rw <= rx[0];
                ara <= ara_hit;
              end else begin
                i2c_st <= I2C_HOLD;
              end
            end
            I2C_WR: SDA_OE_N <= 1'b0;
            default: SDA_OE_N <= 1'b1;
          endcase
        end else if (bit_cnt == 4'h9) begin
          bit_cnt <= 4'h0;
          if (i2c_st == I2C_ADDR && rw) begin
            i2c_st <= I2C_RD;
            tx <= tx_byte;
            SDA_OE_N <= tx_byte[7];
            byte_sel <= ~byte_sel;
          end else if (i2c_st == I2C_ADDR) begin
            i2c_st <= I2C_WR;
            SDA_OE_N <= 1'b1;
          end else if (i2c_st == I2C_RD && ara) begin
            ara_done <= 1'b1;
            i2c_st <= I2C_HOLD;
            SDA_OE_N <= 1'b1;
          end else if (i2c_st == I2C_RD && host_ack) begin
            tx <= tx_byte;
            SDA_OE_N <= tx_byte[7];
            byte_sel <= ~byte_sel;
          end else if (i2c_st == I2C_RD) begin
            i2c_st <= I2C_HOLD;
            SDA_OE_N <= 1'b1;
          end else begin
            SDA_OE_N <= 1'b1;
          end
        end else if (i2c_st == I2C_RD) begin
          tx <= {tx[6:0], 1'b1};
          SDA_OE_N <= tx[6];
        end
      end
    end
  end

endmodule

// *** lsri_top_props.sv ***
`timescale 1ns/1ns
module lsri_top_props #(
  parameter int TIMEOUT_CYC = lsri_pkg::TIMEOUT_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N,
  input wire logic INT_O,
  input wire lsri_pkg::lsri_conv_req_s CONV_REQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  logic rd_take;
  int unsigned low_cnt;
  assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;
  // saturating count of raw clock-low cycles
  always_ff @(posedge CLK) begin
    if (SRST || SCL_I) begin
      low_cnt <= 0;
    end else if (low_cnt < TIMEOUT_CYC + 100) begin
      low_cnt <= low_cnt + 1;
    end
  end
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  a_int_open_drain: assert property (INT_O == 1'h0)
    else $error("interrupt pin driven high");
  a_sda_open_drain: assert property (SDA_O == 1'h0)
    else $error("data pin driven high");
  // margin of sync stages, clock low lasts far longer
  a_sda_on_low: assert property ($changed(SDA_OE_N) |-> !SCL_I)
    else $error("data pin changed while clock high");
  a_start_pulse: assert property (CONV_REQ.start |=> !CONV_REQ.start)
    else $error("conversion start longer than one cycle");
  a_assess_range: assert property (CONV_REQ.start && CONV_REQ.assess |-> CONV_REQ.range == 4'hB)
    else $error("assessment not at top range");
  // auto code never sent as range
  a_range_legal: assert property (CONV_REQ.start |-> CONV_REQ.range <= 4'hB)
    else $error("requested range out of table");
  a_read_idle: assert property (!rd_take |=> HRDATA == 32'h0)
    else $error("read data without read");
  a_unmapped_zero: assert property (rd_take && HADDR[7:0] > 8'h0C |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_bus_timeout: assert property (low_cnt > TIMEOUT_CYC + 8 |-> SDA_OE_N)
    else $error("data pin held past bus timeout");
endmodule

bind lsri_top lsri_top_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_lsri_top_props (
  .CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SCL_I(SCL_I),
  .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N), .INT_O(INT_O), .CONV_REQ(CONV_REQ)
);

// *** lsri_top_tb.sv ***
`timescale 1ns/1ns
module lsri_top_tb;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] addr_sel = 2'h0;
  lsri_pkg::lsri_conv_res_s conv_res = '0;
  lsri_pkg::lsri_conv_req_s conv_req;
  wire [31:0] hrdata;
  wire hready, sda_o, sda_oe_n, int_o, int_oe_n, scl, sda_drv, sda_line, addr_pin;
  int err_count = 0;
  int comparisons = 0;
  logic [31:0] q;
  logic ack;
  logic [15:0] rx;
  logic [11:0] ca, cb;

  always #2 clk = ~clk;
  // pull-up on the shared data wire
  assign sda_line = sda_drv & (sda_oe_n | sda_o);
  assign addr_pin = addr_sel == lsri_pkg::PIN_GND ? 1'h0 : addr_sel == lsri_pkg::PIN_VDD ? 1'h1 :
                    addr_sel == lsri_pkg::PIN_SDA ? sda_line : scl;

  lsri_top #(.TIMEOUT_CYC(2000)) u_lsri_top (
    .CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(), .SCL_I(scl), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
    .ADDR_I(addr_pin), .INT_I(int_oe_n | int_o), .INT_O(int_o), .INT_OE_N(int_oe_n),
    .CONV_REQ(conv_req), .CONV_RES(conv_res)
  );
  lsri_host_model u_lsri_host_model (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    ahb(1'h0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic i2c(input logic [7:0] h, input int st, input int nr = 1);
    u_lsri_host_model.xfer(h, st, nr, ack, rx);
  endtask
  // front end: answers each start after a random delay
  task automatic serve(input logic as, input logic [3:0] rg, input logic [11:0] c,
                       input logic ov);
    int n;
    for (n = 0; n < 4000 && conv_req.start !== 1'h1; n++) @(posedge clk);
    chk("req_seen", 32'h1, {31'h0, conv_req.start});
    chk("req_assess", {31'h0, as}, {31'h0, conv_req.assess});
    chk("req_range", {28'h0, rg}, {28'h0, conv_req.range});
    repeat ($urandom_range(30, 3)) @(posedge clk);
    conv_res <= '{valid: 1'h1, ovf: ov, code: c};
    @(posedge clk);
    conv_res <= '{valid: 1'h0, ovf: 1'h1, code: 12'($urandom)};
  endtask
  task automatic conv(input logic [31:0] cfg, input logic [11:0] c);
    ahb(1'h1, lsri_pkg::OFF_CONFIG, cfg);
    serve(1'h0, 4'h0, c, 1'h0);
    chk("req_time", {31'h0, cfg[lsri_pkg::CFG_CT_BIT]}, {31'h0, conv_req.long_time});
  endtask
  task automatic pin(input logic e);
    repeat (4) @(posedge clk);
    chk("int_pin", {31'h0, e}, {31'h0, int_oe_n});
  endtask
  function automatic logic [3:0] pick(input logic [11:0] c);
    for (int r = 0; r < 11; r++) begin
      if ((int'(c) << (11 - r)) < int'(lsri_pkg::AR_HIGH_THR)) return 4'(r);
    end
    return 4'hB;
  endfunction

  initial begin
    #200000;
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(50499));
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    rdc(lsri_pkg::OFF_CONFIG, 32'hC810, "cfg_rst"); // latch set at reset
    rdc(lsri_pkg::OFF_HIGH, 32'hBFFF, "high_rst");
    rdc(8'h10, 32'h0, "unmapped");
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      addr_sel <= 2'(s);
      i2c({lsri_pkg::ADDR_BASE, 2'(s), 1'h0}, 0);
      chk("ack_own", 32'h0, {31'h0, ack}); // own address acked
      i2c({lsri_pkg::ADDR_BASE, 2'(s + 1), 1'h0}, 0);
      chk("ack_other", 32'h1, {31'h0, ack}); // pin sampled anew
    end
    @(posedge clk);
    addr_sel <= 2'h0;
    ahb(1'h1, lsri_pkg::OFF_HIGH, 32'h0100);
    ahb(1'h1, lsri_pkg::OFF_LOW, 32'h0050);
    ca = 12'($urandom_range(4095, 257));
    conv(32'h0210, ca);
    pin(1'h0); // active pulls low
    rdc(lsri_pkg::OFF_RESULT, {20'h0, ca}, "result"); // result reported
    rdc(lsri_pkg::OFF_CONFIG, 32'h00D0, "cfg_flag"); // high flag held
    rdc(lsri_pkg::OFF_CONFIG, 32'h0010, "cfg_clr"); // read clears
    pin(1'h1); // pin released
    conv(32'h0A11, 12'h010);
    pin(1'h1); // one low short of count
    conv(32'h0211, ca);
    pin(1'h1); // changed outcome restarts
    conv(32'h0211, ca);
    pin(1'h0); // second high triggers
    i2c({lsri_pkg::ARA_ADDR, 1'h1}, 0);
    chk("ara_addr", 32'h88, {16'h0, rx}); // alert answered
    pin(1'h1); // pin released
    rdc(lsri_pkg::OFF_CONFIG, 32'h00D1, "cfg_kept"); // flags kept
    conv(32'h0208, ca);
    pin(1'h1); // active released
    i2c({lsri_pkg::ARA_ADDR, 1'h1}, 0);
    chk("ara_none", 32'h1, {31'h0, ack}); // no alert answer
    rdc(lsri_pkg::OFF_CONFIG, 32'h00C8, "cfg_high"); // high flag only
    pin(1'h1); // read leaves pin
    conv(32'h0208, 12'h010);
    pin(1'h0); // inactive pulled low
    rdc(lsri_pkg::OFF_CONFIG, 32'h00A8, "cfg_low"); // low flag only
    ahb(1'h1, lsri_pkg::OFF_LOW, 32'hC000);
    conv(32'h0210, 12'h080);
    pin(1'h0); // conversion end raises
    ahb(1'h0, lsri_pkg::OFF_CONFIG, 32'h0);
    pin(1'h1); // read releases
    ca = 12'($urandom_range(4095, 1));
    cb = 12'($urandom_range(4095, 1));
    ahb(1'h1, lsri_pkg::OFF_CONFIG, 32'hC210);
    serve(1'h1, 4'hB, ca, 1'h0); // assessment first
    serve(1'h0, pick(ca), cb, 1'h1); // picked range overflows
    serve(1'h1, 4'hB, cb, 1'h0); // reassessment
    serve(1'h0, pick(cb), ca, 1'h0); // corrected range
    repeat (4) @(posedge clk);
    rdc(lsri_pkg::OFF_RESULT, {16'h0, pick(cb), ca}, "auto_res"); // abort unreported
    i2c({lsri_pkg::ADDR_BASE, 2'h0, 1'h1}, 0, 2);
    chk("rd_byte", {16'h0, pick(cb), ca}, {16'h0, rx}); // msb first
    i2c({lsri_pkg::ADDR_BASE, 2'h0, 1'h0}, 10000);
    chk("ack_stall", 32'h1, {31'h0, ack}); // stuck clock resets
    ahb(1'h0, lsri_pkg::OFF_CONFIG, 32'h0);
    ahb(1'h1, lsri_pkg::OFF_CONFIG, 32'h3210);
    serve(1'h0, 4'h3, 12'h010, 1'h1); // manual range kept
    rdc(lsri_pkg::OFF_CONFIG, 32'h3190, "cfg_ovf"); // manual overflow reported
    print_verdict();
  end
endmodule
